// ---- core/dso_stop_logic.v ----
/*
 * drive stop option logic: parameter objects for quick stop ramp and
 * velocity speed scaling, and the braking action sequencer for the
 * quick stop, shutdown and disable transitions.
 * assumes the power state machine, the ramp generator and the object
 * access agent all run on clk_sys and present one-cycle request pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dso_regs.vh"

module dso_stop_logic
(
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // object access
    input wire obj_req,
    input wire obj_wr,
    input wire [15:0] obj_index,
    input wire [7:0] obj_subindex,
    input wire [31:0] obj_wdata,
    output reg obj_ack_ff,
    output reg obj_abort_ff,
    output reg [31:0] obj_rdata_ff,
    // power state machine events
    input wire qs_enter,
    input wire shutdown_req,
    input wire disable_req,
    input wire resume_req,
    input wire velocity_mode,
    // motor stage
    input wire motor_standstill,
    output reg [1:0] brake_action_ff,
    output reg drive_free_ff,
    output reg motor_energized_ff,
    output reg vl_qs_ramp_apply_ff,
    output reg [31:0] ramp_speed_step_ff,
    output reg [15:0] ramp_time_step_ff,
    // completion report
    output reg done_ff,
    output reg [2:0] done_target_ff,
    output wire busy,
    // speed scaling
    input wire signed [31:0] internal_speed,
    output reg signed [31:0] speed_rpm_ff
);

////////////////////////////////////////////////////////////////////////////
// sequencer states
localparam ST_IDLE = 2'h0;
localparam ST_BRAKE = 2'h1;
localparam ST_HOLD = 2'h2;

reg [31:0] speed_step_ff;
reg [15:0] time_step_ff, qs_code_ff, sd_code_ff, dis_code_ff;
reg signed [31:0] scale_num_ff, scale_den_ff;
reg [1:0] state_ff, nxt_state, nxt_action;
reg [2:0] target_ff, nxt_target, nxt_done_target;
reg hold_after_ff, nxt_hold_after, nxt_free, nxt_energized, nxt_done;
reg signed [63:0] speed_prod_ff;
// quotient kept at full width; only its low word is handed on
wire signed [63:0] speed_quot = speed_prod_ff / scale_den_ff;

////////////////////////////////////////////////////////////////////////////
// option code checks; reserved codes are refused at write time
function code_ok;
    input [15:0] index;
    input [15:0] code;
    begin
        if (index == `DSO_IDX_QS_CODE)
            code_ok = (code == `DSO_OPT_FREE) || (code == `DSO_OPT_SLOW) ||
                      (code == `DSO_OPT_QUICK) || (code == `DSO_OPT_SLOW_HOLD) ||
                      (code == `DSO_OPT_QUICK_HOLD);
        else
            code_ok = (code == `DSO_OPT_FREE) || (code == `DSO_OPT_SLOW);
    end
endfunction

// maps a quick stop code onto its braking action
function [1:0] qs_action;
    input [15:0] code;
    begin
        case (code)
            `DSO_OPT_FREE: qs_action = `DSO_ACT_IMMEDIATE;
            `DSO_OPT_SLOW: qs_action = `DSO_ACT_SLOW;
            `DSO_OPT_SLOW_HOLD: qs_action = `DSO_ACT_SLOW;
            default: qs_action = `DSO_ACT_QUICK;
        endcase
    end
endfunction

assign busy = (state_ff != ST_IDLE);

////////////////////////////////////////////////////////////////////////////
// object dictionary access: read, write, abort on bad access
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        obj_ack_ff <= 1'b0;
        obj_abort_ff <= 1'b0;
        obj_rdata_ff <= 32'h00000000;
        speed_step_ff <= `DSO_RST_SPEED_STEP;
        time_step_ff <= `DSO_RST_TIME_STEP;
        scale_num_ff <= `DSO_RST_SCALE_NUM;
        scale_den_ff <= `DSO_RST_SCALE_DEN;
        qs_code_ff <= `DSO_RST_QS_CODE;
        sd_code_ff <= `DSO_RST_SD_CODE;
        dis_code_ff <= `DSO_RST_DIS_CODE;
    end
    else
    begin
        obj_ack_ff <= obj_req;
        obj_abort_ff <= 1'b0;
        obj_rdata_ff <= 32'h00000000;
        if (obj_req)
        begin
            case (obj_index)
                `DSO_IDX_QS_RAMP, `DSO_IDX_SCALE:
                begin
                    if (obj_subindex == `DSO_SUB_COUNT)
                    begin
                        if (obj_wr)
                            obj_abort_ff <= 1'b1; // entry count is read only
                        else
                            obj_rdata_ff <= {24'h000000, `DSO_RST_COUNT};
                    end
                    else if (obj_subindex == `DSO_SUB_FIRST)
                    begin
                        if (obj_index == `DSO_IDX_QS_RAMP)
                        begin
                            if (obj_wr)
                                speed_step_ff <= obj_wdata;
                            obj_rdata_ff <= speed_step_ff;
                        end
                        else
                        begin
                            if (obj_wr)
                                scale_num_ff <= obj_wdata;
                            obj_rdata_ff <= scale_num_ff;
                        end
                    end
                    else if (obj_subindex == `DSO_SUB_SECOND)
                    begin
                        if (obj_index == `DSO_IDX_QS_RAMP)
                        begin
                            if (obj_wr)
                                time_step_ff <= obj_wdata[15:0];
                            obj_rdata_ff <= {16'h0000, time_step_ff};
                        end
                        else
                        begin
                            if (obj_wr && obj_wdata != 32'h00000000)
                                scale_den_ff <= obj_wdata;
                            if (obj_wr && obj_wdata == 32'h00000000)
                                obj_abort_ff <= 1'b1; // zero divisor refused
                            obj_rdata_ff <= scale_den_ff;
                        end
                    end
                    else
                        obj_abort_ff <= 1'b1;
                end
                `DSO_IDX_QS_CODE, `DSO_IDX_SD_CODE, `DSO_IDX_DIS_CODE:
                begin
                    if (obj_subindex != `DSO_SUB_COUNT)
                        obj_abort_ff <= 1'b1;
                    else if (obj_wr && !code_ok(obj_index, obj_wdata[15:0]))
                        obj_abort_ff <= 1'b1;
                    else if (obj_index == `DSO_IDX_QS_CODE)
                    begin
                        if (obj_wr)
                            qs_code_ff <= obj_wdata[15:0];
                        obj_rdata_ff <= {{16{qs_code_ff[15]}}, qs_code_ff};
                    end
                    else if (obj_index == `DSO_IDX_SD_CODE)
                    begin
                        if (obj_wr)
                            sd_code_ff <= obj_wdata[15:0];
                        obj_rdata_ff <= {{16{sd_code_ff[15]}}, sd_code_ff};
                    end
                    else
                    begin
                        if (obj_wr)
                            dis_code_ff <= obj_wdata[15:0];
                        obj_rdata_ff <= {{16{dis_code_ff[15]}}, dis_code_ff};
                    end
                end
                default:
                    obj_abort_ff <= 1'b1;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// braking action sequencer
always @*
begin
    nxt_state = state_ff;
    nxt_target = target_ff;
    nxt_hold_after = hold_after_ff;
    nxt_action = brake_action_ff;
    nxt_free = drive_free_ff;
    nxt_energized = motor_energized_ff;
    nxt_done = 1'b0;
    nxt_done_target = done_target_ff;
    case (state_ff)
        ST_IDLE:
        begin
            nxt_free = 1'b0;
            nxt_energized = 1'b1;
            nxt_action = `DSO_ACT_NONE;
            if (qs_enter)
            begin
                nxt_action = qs_action(qs_code_ff);
                nxt_hold_after = (qs_code_ff == `DSO_OPT_SLOW_HOLD) ||
                                 (qs_code_ff == `DSO_OPT_QUICK_HOLD);
                nxt_target = nxt_hold_after ? `DSO_TGT_QS_ACTIVE
                                            : `DSO_TGT_SWITCH_ON_DISABLED;
                nxt_state = ST_BRAKE;
            end
            else if (shutdown_req || disable_req)
            begin
                nxt_hold_after = 1'b0;
                nxt_target = shutdown_req ? `DSO_TGT_READY : `DSO_TGT_SWITCHED_ON;
                if ((shutdown_req ? sd_code_ff : dis_code_ff) == `DSO_OPT_FREE)
                begin
                    nxt_free = 1'b1;
                    nxt_energized = 1'b0;
                    nxt_done = 1'b1;
                    nxt_done_target = nxt_target;
                end
                else
                begin
                    nxt_action = `DSO_ACT_SLOW;
                    nxt_state = ST_BRAKE;
                end
            end
        end
        ST_BRAKE:
        begin
            if (motor_standstill)
            begin
                nxt_action = `DSO_ACT_NONE;
                nxt_done = 1'b1;
                nxt_done_target = target_ff;
                if (hold_after_ff)
                    nxt_state = ST_HOLD;
                else
                begin
                    nxt_energized = 1'b0;
                    nxt_state = ST_IDLE;
                end
            end
        end
        ST_HOLD:
        begin
            nxt_energized = 1'b1;
            if (resume_req)
            begin
                nxt_done = 1'b1;
                nxt_done_target = `DSO_TGT_OP_ENABLED;
                nxt_state = ST_IDLE;
            end
        end
        default:
            nxt_state = ST_IDLE;
    endcase
end

// sequencer registers, ramp values for the ramp generator, speed scaling
// (multiply, then divide one cycle later)
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        state_ff <= ST_IDLE;
        target_ff <= `DSO_TGT_SWITCH_ON_DISABLED;
        hold_after_ff <= 1'b0;
        brake_action_ff <= `DSO_ACT_NONE;
        drive_free_ff <= 1'b0;
        motor_energized_ff <= 1'b0;
        done_ff <= 1'b0;
        done_target_ff <= `DSO_TGT_SWITCH_ON_DISABLED;
        vl_qs_ramp_apply_ff <= 1'b0;
        ramp_speed_step_ff <= `DSO_RST_SPEED_STEP;
        ramp_time_step_ff <= `DSO_RST_TIME_STEP;
        speed_prod_ff <= 64'h0000000000000000;
        speed_rpm_ff <= 32'h00000000;
    end
    else
    begin
        state_ff <= nxt_state;
        target_ff <= nxt_target;
        hold_after_ff <= nxt_hold_after;
        brake_action_ff <= nxt_action;
        drive_free_ff <= nxt_free;
        motor_energized_ff <= nxt_energized;
        done_ff <= nxt_done;
        done_target_ff <= nxt_done_target;
        vl_qs_ramp_apply_ff <= velocity_mode && (nxt_action == `DSO_ACT_QUICK);
        ramp_speed_step_ff <= speed_step_ff;
        ramp_time_step_ff <= time_step_ff;
        speed_prod_ff <= internal_speed * scale_num_ff;
        speed_rpm_ff <= speed_quot[31:0];
    end
end

endmodule
`default_nettype wire

// ---- include/dso_regs.vh ----
/*
 * object indexes, subindexes, preset values and option codes of the
 * drive stop option block.
 * assumes the includer uses them at the widths given here.
 */
`ifndef DSO_REGS_VH
`define DSO_REGS_VH

// object indexes
`define DSO_IDX_QS_RAMP 16'h604a
`define DSO_IDX_SCALE 16'h604c
`define DSO_IDX_QS_CODE 16'h605a
`define DSO_IDX_SD_CODE 16'h605b
`define DSO_IDX_DIS_CODE 16'h605c

// subindexes
`define DSO_SUB_COUNT 8'h00
`define DSO_SUB_FIRST 8'h01
`define DSO_SUB_SECOND 8'h02

// preset values
`define DSO_RST_COUNT 8'h02
`define DSO_RST_SPEED_STEP 32'h00001388
`define DSO_RST_TIME_STEP 16'h0001
`define DSO_RST_SCALE_NUM 32'h00000001
`define DSO_RST_SCALE_DEN 32'h00000001
`define DSO_RST_QS_CODE 16'h0002
`define DSO_RST_SD_CODE 16'h0001
`define DSO_RST_DIS_CODE 16'h0001

// option codes
`define DSO_OPT_FREE 16'h0000
`define DSO_OPT_SLOW 16'h0001
`define DSO_OPT_QUICK 16'h0002
`define DSO_OPT_SLOW_HOLD 16'h0005
`define DSO_OPT_QUICK_HOLD 16'h0006

// braking actions driven to the motor stage
`define DSO_ACT_NONE 2'h0
`define DSO_ACT_SLOW 2'h1
`define DSO_ACT_QUICK 2'h2
`define DSO_ACT_IMMEDIATE 2'h3

// target states reported when an action completes
`define DSO_TGT_SWITCH_ON_DISABLED 3'h0
`define DSO_TGT_READY 3'h1
`define DSO_TGT_SWITCHED_ON 3'h2
`define DSO_TGT_QS_ACTIVE 3'h3
`define DSO_TGT_OP_ENABLED 3'h4

`endif

// ---- tb/dso_checker.sv ----
/*
 * port checker for the stop option block.
 * assumes clk_sys and the active-low resetn of that block.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dso_regs.vh"
module dso_checker
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // object port
    input wire logic obj_req,
    input wire logic obj_wr,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_subindex,
    input wire logic [31:0] obj_wdata,
    input wire logic obj_ack_ff,
    input wire logic obj_abort_ff,
    // events and motor stage
    input wire logic qs_enter,
    input wire logic motor_standstill,
    input wire logic [1:0] brake_action_ff,
    input wire logic drive_free_ff,
    input wire logic vl_qs_ramp_apply_ff,
    input wire logic done_ff,
    input wire logic [2:0] done_target_ff,
    input wire logic busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // write decodes
    wire wrq = obj_req && obj_wr;
    wire [15:0] wc = obj_wdata[15:0];
    wire rsv = wc > 16'h0006 || wc == 16'h0003 || wc == 16'h0004;
    AST_ACK: assert property (obj_req |=> obj_ack_ff) else $error("no answer");
    AST_ACK_SRC: assert property (obj_ack_ff |-> $past(obj_req)) else $error("stray answer");
    AST_ABORT: assert property (obj_abort_ff |-> obj_ack_ff) else $error("abort alone");
    AST_RSV_QS: assert property (wrq && obj_index == `DSO_IDX_QS_CODE && rsv |=> obj_abort_ff)
        else $error("reserved code taken");
    AST_DEN0: assert property (wrq && obj_index == `DSO_IDX_SCALE && obj_subindex == 8'h02 && obj_wdata == 32'h0
        |=> obj_abort_ff) else $error("zero divisor taken");
    AST_TAKE: assert property (qs_enter && !busy |=> brake_action_ff != `DSO_ACT_NONE)
        else $error("quick stop ignored");
    AST_STAY: assert property (brake_action_ff != 2'h0 && !motor_standstill |=> $stable(brake_action_ff))
        else $error("brake changed early");
    AST_DONE: assert property (brake_action_ff != 2'h0 && motor_standstill |=> done_ff)
        else $error("late done");
    AST_VL: assert property ($rose(vl_qs_ramp_apply_ff) |-> brake_action_ff == `DSO_ACT_QUICK)
        else $error("ramp apply without quick");
    AST_FREE: assert property (drive_free_ff |=> !drive_free_ff) else $error("free too long");
    // main scenarios
    cover property (done_ff && done_target_ff == `DSO_TGT_QS_ACTIVE);
    cover property (done_ff && done_target_ff == `DSO_TGT_OP_ENABLED);
    cover property (obj_abort_ff);
endmodule
bind dso_stop_logic dso_checker u_chk (.clk_sys, .resetn, .obj_req, .obj_wr, .obj_index, .obj_subindex,
    .obj_wdata, .obj_ack_ff, .obj_abort_ff, .qs_enter, .motor_standstill, .brake_action_ff, .drive_free_ff,
    .vl_qs_ramp_apply_ff, .done_ff, .done_target_ff, .busy);
`default_nettype wire

// ---- tb/dso_master.sv ----
/*
 * fieldbus master model: one object access at a time.
 * assumes requests are launched at falling edges of clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module dso_master
(
    // clock
    input wire logic clk_sys,
    // object port
    output logic obj_req,
    output logic obj_wr,
    output logic [15:0] obj_index,
    output logic [7:0] obj_subindex,
    output logic [31:0] obj_wdata,
    input wire logic obj_ack_ff,
    input wire logic obj_abort_ff,
    input wire logic [31:0] obj_rdata_ff
);
    // idle bus
    initial
    begin
        obj_req = 1'b0;
        obj_wr = 1'b0;
        obj_index = 16'h0000;
        obj_subindex = 8'h00;
        obj_wdata = 32'h0;
    end
    // one request pulse, answer taken in the next cycle
    task acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
        output logic [31:0] q, output logic ab);
        @(negedge clk_sys);
        obj_req = 1'b1;
        obj_wr = w;
        obj_index = i;
        obj_subindex = s;
        obj_wdata = d;
        @(negedge clk_sys);
        obj_req = 1'b0;
        obj_index = ~i;
        obj_wdata = ~d; // released data does not keep its value
        q = obj_rdata_ff;
        ab = obj_ack_ff === 1'b1 ? obj_abort_ff : 1'bx;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/*
 * self-checking bench for the stop option block.
 * assumes the object port contract and a 40 MHz clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic qs_enter = 1'b0, shutdown_req = 1'b0, disable_req = 1'b0, resume_req = 1'b0;
    logic velocity_mode = 1'b0, motor_standstill = 1'b0;
    logic signed [31:0] internal_speed = 32'sh0;
    wire obj_req, obj_wr, obj_ack_ff, obj_abort_ff, drive_free_ff, motor_energized_ff;
    wire vl_qs_ramp_apply_ff, done_ff, busy;
    wire [15:0] obj_index, ramp_time_step_ff;
    wire [7:0] obj_subindex;
    wire [31:0] obj_wdata, obj_rdata_ff, ramp_speed_step_ff;
    wire [1:0] brake_action_ff;
    wire [2:0] done_target_ff;
    wire signed [31:0] speed_rpm_ff;
    integer err_count = 0, n_checks = 0, cyc = 0, seed = 32'hb844;
    // object table and its model contents
    logic [15:0] ix[9] = '{16'h604a, 16'h604a, 16'h604a, 16'h604c, 16'h604c, 16'h604c, 16'h605a, 16'h605b, 16'h605c};
    logic [7:0] sb[9] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00};
    int md[9] = '{2, 32'h1388, 1, 2, 1, 1, 2, 1, 1};
    dso_stop_logic dut (.*);
    dso_master m (.*);
    always #12.5 clk_sys = ~clk_sys;
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            err_count++;
            close_out;
        end
    end
    task wr(input int k, input logic [31:0] d, input logic e);
        logic [31:0] q;
        logic ab;
        m.acc(1'b1, ix[k], sb[k], d, q, ab);
        chk("abort", ab, e);
        if (!e)
            md[k] = d;
    endtask
    task rdall;
        logic [31:0] q;
        logic ab;
        for (int k = 0; k < 9; k++)
        begin
            m.acc(1'b0, ix[k], sb[k], 32'h0, q, ab);
            chk("read", q, md[k]);
            chk("readab", ab, 1'b0);
        end
    endtask
    // one transition: kind 0 quick stop, 1 shutdown, 2 disable
    task ev(input int kind, input int code, input logic [1:0] ea, input logic [2:0] et);
        int n;
        wr(6 + kind, code, 1'b0);
        @(negedge clk_sys);
        velocity_mode = $random(seed) | (code == 2);
        qs_enter = kind == 0;
        shutdown_req = kind == 1;
        disable_req = kind == 2;
        @(negedge clk_sys);
        {qs_enter, shutdown_req, disable_req} = 3'h0;
        chk("act", brake_action_ff, ea);
        chk("busy", busy, ea != 2'h0);
        if (kind == 0)
            chk("vl", vl_qs_ramp_apply_ff, velocity_mode && ea == 2'h2);
        if (ea != 2'h0)
        begin
            disable_req = 1'b1;
            @(negedge clk_sys);
            disable_req = 1'b0;
            chk("drop", brake_action_ff, ea);
            repeat (($random(seed) & 7) + 1) @(negedge clk_sys);
            motor_standstill = 1'b1;
        end
        for (n = 0; n < 6 && done_ff !== 1'b1; n++)
            @(negedge clk_sys);
        chk("done", done_ff, 1'b1);
        chk("target", done_target_ff, et);
        chk("free", drive_free_ff, ea == 2'h0);
        if (kind == 0 && et == 3'h0)
            chk("energ", motor_energized_ff, 1'b0);
        if (et == 3'h3)
        begin
            chk("energ", motor_energized_ff, 1'b1);
            @(negedge clk_sys);
            resume_req = 1'b1;
            @(negedge clk_sys);
            resume_req = 1'b0;
            chk("resume", {done_ff, done_target_ff}, 4'hc);
        end
        motor_standstill = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    initial
    begin
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        rdall;
        $display("test presets done");
        wr(0, 7, 1'b1);
        wr(3, 7, 1'b1);
        wr(1, $random(seed), 1'b0);
        wr(2, $random(seed) & 16'hffff, 1'b0);
        wr(5, 0, 1'b1);
        wr(6, 3, 1'b1);
        wr(7, 2, 1'b1);
        wr(8, 4, 1'b1);
        rdall;
        chk("step", ramp_speed_step_ff, md[1]);
        chk("time", ramp_time_step_ff, md[2]);
        $display("test objects done");
        repeat (8)
        begin
            wr(4, ($random(seed) & 63) + 1, 1'b0);
            wr(5, ($random(seed) & 15) + 1, 1'b0);
            internal_speed = $random(seed) % 30000;
            repeat (3) @(negedge clk_sys);
            chk("rpm", speed_rpm_ff, internal_speed * md[4] / md[5]);
        end
        $display("test scaling done");
        ev(0, 0, 2'h3, 3'h0);
        ev(0, 1, 2'h1, 3'h0);
        ev(0, 2, 2'h2, 3'h0);
        ev(0, 5, 2'h1, 3'h3);
        ev(0, 6, 2'h2, 3'h3);
        ev(1, 0, 2'h0, 3'h1);
        ev(1, 1, 2'h1, 3'h1);
        ev(2, 0, 2'h0, 3'h2);
        ev(2, 1, 2'h1, 3'h2);
        $display("test actions done");
        close_out;
    end
endmodule
`default_nettype wire
